// File: hw/wdt_timer.sv
`timescale 1ns/10ps
// Operation
// RULE1 - 16-bit load register, reset zero, copied into counter on each load or reload; code copies it only on reload, never on a load register write
// RULE2 - Read-only count register shows live counter, resets to all ones, ignores writes
// RULE3 - Control bit 8 set counts up, clear counts down
// RULE4 - Control bit 7 enables counting; clear holds the counter
// RULE5 - Control bit 6 set is periodic, clear is free-running
// RULE6 - Control bit 5 selects watchdog mode, off after reset
// RULE7 - Control bit 4 turns on secure clear, only effective in watchdog mode
// RULE8 - Control bits 3:2 prescale by 1, 16, 256; code 11 acts as 00
// RULE9 - Control bit 1 makes watchdog expiry raise an interrupt instead of reset
// RULE10 - Clear write ends timer interrupt normally, restarts timeout in watchdog mode
// RULE11 - Software services the watchdog once in every timeout period
// RULE12 - Secure clear expected value comes from 8-bit LFSR x^8+x^6+x^5+x+1
// RULE13 - Seed is written to clear register before watchdog mode; captured as expected
// RULE14 - Matching secure service write reloads counter and advances LFSR
// RULE15 - Mismatching secure service write resets the chip at once
// RULE16 - Expected value zero always forces an immediate reset
// RULE17 - The LFSR state has no read path
// RULE18 - Watchdog counts down from load value to zero, then reset or interrupt
// RULE19 - Accepted service write reloads from load value and starts a new period
// RULE20 - In watchdog mode load and control registers ignore writes until reset
// RULE21 - Software programs load value before setting watchdog enable
// RULE22 - Normal mode terminal count raises interrupt; periodic reloads, free-running wraps
// RULE23 - Counter advances per prescaled 32 kHz tick; prescaler restarts on reload
module wdt_timer #(
  parameter int SRC_DIV = wdt_pkg::WDT_SRC_DIV
) (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic [31:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [31:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic timer_irq,
  output logic wdt_reset_req
);
  logic [15:0] load_value;
  logic [15:0] count_value;
  wdt_pkg::wdt_ctrl_t ctrl;
  wdt_pkg::wdt_ctrl_t ctl_new;
  wdt_pkg::wdt_wreq_t wreq;
  wdt_pkg::wdt_wr_state_t wr_state;
  wdt_pkg::wdt_rd_state_t rd_state;
  logic aw_held;
  logic w_held;
  logic do_wr;
  logic wr_hit;
  logic rd_hit;
  logic ld_wr;
  logic ctl_wr;
  logic svc_wr;
  logic enter_wd;
  logic secure_on;
  logic svc_bad;
  logic svc_ok;
  logic run;
  logic down;
  logic at_term;
  logic expire;
  logic wd_reset_evt;
  logic irq_set;
  logic irq_clr;
  logic reload;
  logic tick;
  logic [7:0] expected;
  logic [31:0] rd_mux;

  function automatic logic [15:0] merge16(
    input logic [15:0] old,
    input logic [15:0] data,
    input logic [1:0] strb
  );
    merge16 = {strb[1] ? data[15:8] : old[15:8], strb[0] ? data[7:0] : old[7:0]};
  endfunction

  // Write channel: address and data held until both are in
  assign s_axi_awready = !aw_held && wr_state == wdt_pkg::WDT_WR_IDLE;
  assign s_axi_wready = !w_held && wr_state == wdt_pkg::WDT_WR_IDLE;
  assign s_axi_bvalid = wr_state == wdt_pkg::WDT_WR_RESP;
  assign do_wr = aw_held && w_held && wr_state == wdt_pkg::WDT_WR_IDLE;
  assign wr_hit = wreq.addr == wdt_pkg::WDT_LOAD_ADDR || wreq.addr == wdt_pkg::WDT_COUNT_ADDR
    || wreq.addr == wdt_pkg::WDT_CTRL_ADDR || wreq.addr == wdt_pkg::WDT_CLEAR_ADDR;

  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      wreq <= '0;
    end
    else
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_held <= 1'b1;
        wreq.addr <= s_axi_awaddr;
      end
      else if (do_wr)
        aw_held <= 1'b0;
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_held <= 1'b1;
        wreq.data <= s_axi_wdata;
        wreq.strb <= s_axi_wstrb;
      end
      else if (do_wr)
        w_held <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      wr_state <= wdt_pkg::WDT_WR_IDLE;
      s_axi_bresp <= wdt_pkg::WDT_RESP_OKAY;
    end
    else
    begin
      unique case (wr_state)
        wdt_pkg::WDT_WR_IDLE:
        begin
          if (do_wr)
          begin
            wr_state <= wdt_pkg::WDT_WR_RESP;
            s_axi_bresp <= wr_hit ? wdt_pkg::WDT_RESP_OKAY : wdt_pkg::WDT_RESP_SLVERR;
          end
        end
        wdt_pkg::WDT_WR_RESP:
        begin
          if (s_axi_bready)
            wr_state <= wdt_pkg::WDT_WR_IDLE;
        end
        default: wr_state <= wdt_pkg::WDT_WR_IDLE;
      endcase
    end
  end

  // Register write decode; the count register has no write path
  assign ld_wr = do_wr && wreq.addr == wdt_pkg::WDT_LOAD_ADDR; // RULE2
  assign ctl_wr = do_wr && wreq.addr == wdt_pkg::WDT_CTRL_ADDR;
  assign svc_wr = do_wr && wreq.addr == wdt_pkg::WDT_CLEAR_ADDR && wreq.strb[0];
  assign ctl_new = wdt_pkg::wdt_ctrl_t'(merge16(ctrl, wreq.data[15:0], wreq.strb[1:0])
    & wdt_pkg::WDT_CTRL_WMASK);
  assign enter_wd = ctl_wr && !ctrl.wd_mode && ctl_new.wd_mode; // RULE6

  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
      load_value <= wdt_pkg::WDT_LOAD_RST; // RULE1
    else if (ld_wr && !ctrl.wd_mode) // RULE20
      load_value <= merge16(load_value, wreq.data[15:0], wreq.strb[1:0]); // RULE1
  end

  // Locked once watchdog mode is on; only the chip reset unlocks it
  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
      ctrl <= wdt_pkg::wdt_ctrl_t'(wdt_pkg::WDT_CTRL_RST); // RULE6
    else if (ctl_wr && !ctrl.wd_mode) // RULE20
      ctrl <= ctl_new;
  end

  // Service write checking
  assign secure_on = ctrl.wd_mode && ctrl.secure; // RULE7
  assign svc_bad = svc_wr && secure_on && (wreq.data[7:0] != expected // RULE15
    || expected == wdt_pkg::WDT_LFSR_ZERO); // RULE16
  assign svc_ok = svc_wr && ctrl.wd_mode && !svc_bad; // RULE19

  wdt_lfsr u_lfsr (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .load(svc_wr && !ctrl.wd_mode), // RULE13
    .advance(svc_ok && ctrl.secure), // RULE14
    .seed(wreq.data[7:0]),
    .value(expected)
  );

  // Counting; watchdog mode always runs downward
  assign run = ctrl.wd_mode || ctrl.enable; // RULE4
  assign down = ctrl.wd_mode || !ctrl.count_up; // RULE3 RULE18
  assign at_term = down ? count_value == wdt_pkg::WDT_COUNT_ZERO
    : count_value == wdt_pkg::WDT_COUNT_MAX;
  assign expire = tick && run && at_term;
  assign wd_reset_evt = expire && ctrl.wd_mode && !ctrl.irq_opt; // RULE9 RULE18
  assign reload = enter_wd || svc_ok || (expire && (ctrl.periodic || ctrl.wd_mode)); // RULE5

  wdt_presc #(
    .SRC_DIV(SRC_DIV)
  ) u_presc (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .restart(reload), // RULE23
    .sel(ctrl.prescale),
    .tick(tick)
  );

  // Free-running wraps by plain overflow of the step
  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
      count_value <= wdt_pkg::WDT_COUNT_RST; // RULE2
    else if (reload)
      count_value <= load_value; // RULE1 RULE19 RULE22
    else if (tick && run)
      count_value <= down ? count_value - wdt_pkg::WDT_COUNT_STEP // RULE23
        : count_value + wdt_pkg::WDT_COUNT_STEP; // RULE3
  end

  // Set beats a clear landing in the same cycle
  assign irq_set = expire && (!ctrl.wd_mode || ctrl.irq_opt); // RULE9 RULE22
  assign irq_clr = svc_wr && !svc_bad; // RULE10

  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
      timer_irq <= 1'b0;
    else if (irq_set)
      timer_irq <= 1'b1;
    else if (irq_clr)
      timer_irq <= 1'b0;
  end

  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
      wdt_reset_req <= 1'b0;
    else
      wdt_reset_req <= svc_bad || wd_reset_evt; // RULE15 RULE18
  end

  // Read channel; the clear register reads zero so the LFSR stays hidden
  assign s_axi_arready = rd_state == wdt_pkg::WDT_RD_IDLE;
  assign s_axi_rvalid = rd_state == wdt_pkg::WDT_RD_DATA;

  always_comb
  begin
    rd_hit = 1'b1;
    unique case (s_axi_araddr)
      wdt_pkg::WDT_LOAD_ADDR: rd_mux = 32'(load_value);
      wdt_pkg::WDT_COUNT_ADDR: rd_mux = 32'(count_value); // RULE2
      wdt_pkg::WDT_CTRL_ADDR: rd_mux = 32'(ctrl);
      wdt_pkg::WDT_CLEAR_ADDR: rd_mux = '0; // RULE17
      default:
      begin
        rd_mux = '0;
        rd_hit = 1'b0;
      end
    endcase
  end

  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      rd_state <= wdt_pkg::WDT_RD_IDLE;
      s_axi_rdata <= '0;
      s_axi_rresp <= wdt_pkg::WDT_RESP_OKAY;
    end
    else
    begin
      unique case (rd_state)
        wdt_pkg::WDT_RD_IDLE:
        begin
          if (s_axi_arvalid)
          begin
            rd_state <= wdt_pkg::WDT_RD_DATA;
            s_axi_rdata <= rd_mux;
            s_axi_rresp <= rd_hit ? wdt_pkg::WDT_RESP_OKAY : wdt_pkg::WDT_RESP_SLVERR;
          end
        end
        wdt_pkg::WDT_RD_DATA:
        begin
          if (s_axi_rready)
            rd_state <= wdt_pkg::WDT_RD_IDLE;
        end
        default: rd_state <= wdt_pkg::WDT_RD_IDLE;
      endcase
    end
  end

  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!rst_n);

  sequence s_secure_service;
    svc_wr && secure_on;
  endsequence

  sequence s_wrong_value;
    s_secure_service ##0 wreq.data[7:0] != expected;
  endsequence

  property p_count_reset;
    $rose(rst_n) |-> count_value == wdt_pkg::WDT_COUNT_RST;
  endproperty
  a_count_reset: assert property (p_count_reset) // RULE2
    else $error("count not all ones after reset");

  property p_count_down;
    tick && run && !reload && down |=> count_value == $past(count_value) - 16'h0001;
  endproperty
  a_count_down: assert property (p_count_down) // RULE3
    else $error("counter did not step down on tick");

  property p_hold;
    !run && !reload |=> $stable(count_value);
  endproperty
  a_hold: assert property (p_hold) // RULE4
    else $error("counter moved while disabled");

  property p_irq_opt;
    expire && ctrl.wd_mode && ctrl.irq_opt && !svc_bad |=> timer_irq && !wdt_reset_req;
  endproperty
  a_irq_opt: assert property (p_irq_opt) // RULE9
    else $error("watchdog expiry with irq option did not raise irq");

  property p_irq_clear;
    svc_wr && !ctrl.wd_mode && !irq_set |=> !timer_irq;
  endproperty
  a_irq_clear: assert property (p_irq_clear) // RULE10
    else $error("clear write left interrupt pending");

  property p_good_service;
    svc_ok |=> count_value == $past(load_value) ##1 !wdt_reset_req;
  endproperty
  a_good_service: assert property (p_good_service) // RULE14
    else $error("accepted service write did not reload counter");

  property p_bad_service;
    s_wrong_value |=> wdt_reset_req;
  endproperty
  a_bad_service: assert property (p_bad_service) // RULE15
    else $error("mismatching service write did not reset");

  property p_zero_expected;
    s_secure_service ##0 expected == 8'h00 |=> wdt_reset_req;
  endproperty
  a_zero_expected: assert property (p_zero_expected) // RULE16
    else $error("zero expected value did not force reset");

  property p_wd_expire;
    expire && ctrl.wd_mode && !ctrl.irq_opt |=> wdt_reset_req && !$rose(timer_irq);
  endproperty
  a_wd_expire: assert property (p_wd_expire) // RULE18
    else $error("watchdog expiry did not request reset");

  property p_lock;
    ctrl.wd_mode && do_wr |=> $stable(load_value) && $stable(ctrl);
  endproperty
  a_lock: assert property (p_lock) // RULE20
    else $error("locked register changed in watchdog mode");

  property p_periodic;
    expire && !ctrl.wd_mode && ctrl.periodic |=> count_value == $past(load_value);
  endproperty
  a_periodic: assert property (p_periodic) // RULE22
    else $error("periodic terminal count did not reload");
endmodule

// File: include/wdt_pkg.sv
package wdt_pkg;
  // Register map, byte addresses on the register bus
  localparam logic [31:0] WDT_LOAD_ADDR = 32'hffff_0360;
  localparam logic [31:0] WDT_COUNT_ADDR = 32'hffff_0364;
  localparam logic [31:0] WDT_CTRL_ADDR = 32'hffff_0368;
  localparam logic [31:0] WDT_CLEAR_ADDR = 32'hffff_036c;

  // Values after reset
  localparam logic [15:0] WDT_LOAD_RST = 16'h0000;
  localparam logic [15:0] WDT_COUNT_RST = 16'hffff;
  localparam logic [15:0] WDT_CTRL_RST = 16'h0000;
  localparam logic [7:0] WDT_LFSR_RST = 8'h00;

  // Counter limits and step
  localparam logic [15:0] WDT_COUNT_ZERO = 16'h0000;
  localparam logic [15:0] WDT_COUNT_MAX = 16'hffff;
  localparam logic [15:0] WDT_COUNT_STEP = 16'h0001;

  // Writable control bits; the rest read as zero
  localparam logic [15:0] WDT_CTRL_WMASK = 16'h01fe;

  // LFSR feedback taps for x^8 + x^6 + x^5 + x + 1, and the forbidden state
  localparam logic [7:0] WDT_LFSR_TAPS = 8'h63;
  localparam logic [7:0] WDT_LFSR_ZERO = 8'h00;

  // Timer source: 32 kHz tick derived from the 100 MHz bus clock
  localparam int WDT_CLK_HZ = 100_000_000;
  localparam int WDT_SRC_HZ = 32_768;
  localparam int WDT_SRC_DIV = WDT_CLK_HZ / WDT_SRC_HZ;

  // Prescaler select codes and ratios
  localparam logic [1:0] WDT_PRE_DIV1 = 2'h0;
  localparam logic [1:0] WDT_PRE_DIV16 = 2'h1;
  localparam logic [1:0] WDT_PRE_DIV256 = 2'h2;
  localparam int WDT_PRE_16 = 16;
  localparam int WDT_PRE_256 = 256;

  // Bus responses
  localparam logic [1:0] WDT_RESP_OKAY = 2'h0;
  localparam logic [1:0] WDT_RESP_SLVERR = 2'h2;

  typedef struct packed {
    logic [6:0] rsvd_hi;
    logic count_up;
    logic enable;
    logic periodic;
    logic wd_mode;
    logic secure;
    logic [1:0] prescale;
    logic irq_opt;
    logic rsvd_lo;
  } wdt_ctrl_t;

  typedef struct packed {
    logic [31:0] addr;
    logic [31:0] data;
    logic [3:0] strb;
  } wdt_wreq_t;

  typedef enum logic [1:0] {
    WDT_WR_IDLE = 2'h1,
    WDT_WR_RESP = 2'h2
  } wdt_wr_state_t;

  typedef enum logic [1:0] {
    WDT_RD_IDLE = 2'h1,
    WDT_RD_DATA = 2'h2
  } wdt_rd_state_t;
endpackage

// File: hw/wdt_presc.sv
`timescale 1ns/10ps
module wdt_presc #(
  parameter int SRC_DIV = wdt_pkg::WDT_SRC_DIV
) (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic restart,
  input wire logic [1:0] sel,
  output logic tick
);
  localparam int SW = $clog2(SRC_DIV);
  logic [SW-1:0] src_cnt;
  logic src_tick;
  logic [7:0] pre_cnt;
  logic [7:0] div_last;

  assign src_tick = src_cnt == SW'(SRC_DIV - 1);

  // Code 11 falls back to divide by one
  always_comb
  begin
    unique case (sel)
      wdt_pkg::WDT_PRE_DIV16: div_last = 8'(wdt_pkg::WDT_PRE_16 - 1); // RULE8
      wdt_pkg::WDT_PRE_DIV256: div_last = 8'(wdt_pkg::WDT_PRE_256 - 1); // RULE8
      default: div_last = 8'h00; // RULE8
    endcase
  end

  always_ff @(posedge ref_clk)
  begin
    if (!rst_n || restart)
      src_cnt <= '0; // RULE23
    else if (src_tick)
      src_cnt <= '0;
    else
      src_cnt <= src_cnt + SW'(1);
  end

  // >= keeps a ratio change from stranding the count above the new limit
  always_ff @(posedge ref_clk)
  begin
    if (!rst_n || restart)
      pre_cnt <= 8'h00; // RULE23
    else if (src_tick && pre_cnt >= div_last)
      pre_cnt <= 8'h00;
    else if (src_tick)
      pre_cnt <= pre_cnt + 8'h01;
  end

  assign tick = src_tick && pre_cnt >= div_last; // RULE23
endmodule

// File: hw/wdt_lfsr.sv
`timescale 1ns/10ps
module wdt_lfsr (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic load,
  input wire logic advance,
  input wire logic [7:0] seed,
  output logic [7:0] value
);
  logic [7:0] next_value;

  // Galois form, shifting left
  assign next_value = {value[6:0], 1'b0} ^ (value[7] ? wdt_pkg::WDT_LFSR_TAPS : 8'h00); // RULE12

  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
      value <= wdt_pkg::WDT_LFSR_RST;
    else if (load)
      value <= seed; // RULE13
    else if (advance)
      value <= next_value; // RULE14
  end
endmodule

// File: sim/tb.sv
`timescale 1ns/10ps
module tb;
  localparam int SRC = 4;
  localparam logic [31:0] LD = wdt_pkg::WDT_LOAD_ADDR;
  localparam logic [31:0] CN = wdt_pkg::WDT_COUNT_ADDR;
  localparam logic [31:0] CT = wdt_pkg::WDT_CTRL_ADDR;
  localparam logic [31:0] CL = wdt_pkg::WDT_CLEAR_ADDR;
  logic ref_clk = 1'b0;
  logic rst_n = 1'b0;
  logic [31:0] awaddr = 32'h0000_0000;
  logic [31:0] wdata = 32'h0000_0000;
  logic [31:0] araddr = 32'h0000_0000;
  logic [3:0] wstrb = 4'hf;
  logic awvalid = 1'b0;
  logic wvalid = 1'b0;
  logic arvalid = 1'b0;
  logic awready, wready, bvalid, arready, rvalid, irq, rreq;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  integer seed = 32'hc092_b13b;
  int err_count = 0;
  int total_checks = 0;
  int cyc = 0;
  int rr_count = 0;

  wdt_timer #(.SRC_DIV(SRC)) wdt_timer_inst (.ref_clk(ref_clk), .rst_n(rst_n),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(1'b1),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(1'b1),
    .timer_irq(irq), .wdt_reset_req(rreq));

  always #5 ref_clk = ~ref_clk;

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  // Reset requests are counted so short pulses are never missed
  always @(posedge ref_clk)
  begin
    cyc <= cyc + 1;
    if (rreq === 1'b1)
      rr_count <= rr_count + 1;
    if (cyc == 60000)
    begin
      err_count = err_count + 1;
      $display("FAIL timeout expected 0 seen %0d", cyc);
      print_verdict();
    end
  end

  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    total_checks = total_checks + 1;
    if (g !== e)
    begin
      err_count = err_count + 1;
      $display("FAIL %s expected %h seen %h", n, e, g);
    end
  endtask

  // Cycle counts get a small window for sampling latency
  task automatic chk_win(input string n, input int e, input int g, input int tol);
    total_checks = total_checks + 1;
    if (g < e - tol || g > e + tol)
    begin
      err_count = err_count + 1;
      $display("FAIL %s expected %0d seen %0d", n, e, g);
    end
  endtask

  task automatic axw(input logic [31:0] a, input logic [31:0] d, output logic [1:0] r);
    bit ta;
    bit tw;
    ta = 1'b0;
    tw = 1'b0;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    do
    begin
      @(posedge ref_clk);
      if (!ta && awready === 1'b1)
      begin
        ta = 1'b1;
        awvalid <= 1'b0;
      end
      if (!tw && wready === 1'b1)
      begin
        tw = 1'b1;
        wvalid <= 1'b0;
      end
    end while (bvalid !== 1'b1);
    r = bresp;
  endtask

  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    logic [1:0] r;
    axw(a, d, r);
    chk("bresp", 32'h0000_0000, {30'h0, r});
  endtask

  task automatic rd(input logic [31:0] a, output logic [31:0] d, output logic [1:0] r);
    bit ta;
    ta = 1'b0;
    araddr <= a;
    arvalid <= 1'b1;
    do
    begin
      @(posedge ref_clk);
      if (!ta && arready === 1'b1)
      begin
        ta = 1'b1;
        arvalid <= 1'b0;
      end
    end while (rvalid !== 1'b1);
    d = rdata;
    r = rresp;
  endtask

  task automatic rdc(input string n, input logic [31:0] a, input logic [31:0] e);
    logic [31:0] d;
    logic [1:0] r;
    rd(a, d, r);
    chk(n, e, d);
    chk("rresp", 32'h0000_0000, {30'h0, r});
  endtask

  task automatic reset_dut();
    rst_n <= 1'b0;
    repeat (3) @(posedge ref_clk);
    rst_n <= 1'b1;
    @(posedge ref_clk);
  endtask

  // One edge first so a clear that lands now is already visible
  task automatic wait_irq(output int t);
    @(posedge ref_clk);
    while (irq !== 1'b1)
      @(posedge ref_clk);
    t = cyc;
  endtask

  function automatic logic [7:0] lfsr_next(input logic [7:0] v);
    return {v[6:0], 1'b0} ^ (v[7] ? wdt_pkg::WDT_LFSR_TAPS : 8'h00);
  endfunction

  // Three expiries: the first may straddle the mode change, the last two are clean
  task automatic period_chk(input logic [15:0] c, input logic [15:0] l, input int ratio);
    int t0;
    int t1;
    wr(LD, {16'h0000, l});
    wr(CT, {16'h0000, c});
    wr(CL, 32'h0000_0000);
    wait_irq(t0);
    wr(CL, 32'h0000_0000);
    wait_irq(t0);
    wr(CL, 32'h0000_0000);
    wait_irq(t1);
    chk_win("period", 8 * ratio * SRC, t1 - t0, 1);
    $display("test period ctrl %h done", c);
  endtask

  initial
  begin
    logic [31:0] v;
    logic [31:0] v2;
    logic [1:0] r;
    logic [7:0] e;
    int t0;
    int rr0;
    int ratio [4] = '{1, 16, 256, 1};
    reset_dut();
    rdc("load", LD, 32'h0000_0000);
    rdc("count", CN, 32'h0000_ffff);
    rdc("ctrl", CT, 32'h0000_0000);
    rdc("clear", CL, 32'h0000_0000);
    rd(32'hffff_0370, v, r);
    chk("bad rresp", 32'h0000_0002, {30'h0, r});
    axw(32'hffff_0370, 32'h0000_0000, r);
    chk("bad bresp", 32'h0000_0002, {30'h0, r});
    v = $random(seed);
    wr(LD, v);
    rdc("load", LD, {16'h0000, v[15:0]});
    v2 = $random(seed);
    wstrb <= 4'h2;
    wr(LD, v2);
    wstrb <= 4'hf;
    rdc("load byte", LD, {16'h0000, v2[15:8], v[7:0]});
    wr(CN, $random(seed));
    rdc("count", CN, 32'h0000_ffff);
    v = $random(seed) & 32'h0000_ffdf;
    wr(CT, v);
    rdc("ctrl", CT, v & {16'h0000, wdt_pkg::WDT_CTRL_WMASK});
    $display("test registers done");
    reset_dut();
    for (int i = 0; i < 4; i++)
      period_chk(16'h01c0 | 16'(i << 2), 16'hfff8, ratio[i]);
    wr(CT, 32'h0000_0180);
    wr(CL, 32'h0000_0000);
    wait_irq(t0);
    rd(CN, v, r);
    chk("wrap", 32'h0000_0001, {31'h0, v < 32'h0000_0010});
    wr(CL, 32'h0000_0000);
    @(posedge ref_clk);
    chk("irq clear", 32'h0000_0000, {31'h0, irq});
    period_chk(16'h00c0, 16'h0007, 1);
    wr(CT, 32'h0000_0000);
    rd(CN, v, r);
    repeat (50) @(posedge ref_clk);
    rdc("hold", CN, v);
    $display("test normal mode done");
    reset_dut();
    e = 8'haa;
    wr(CL, {24'h0, e});
    wr(LD, 32'h0000_0040);
    wr(CT, 32'h0000_0032);
    wr(LD, 32'h0000_1234);
    rdc("locked load", LD, 32'h0000_0040);
    wr(CT, 32'h0000_0000);
    rdc("locked ctrl", CT, 32'h0000_0032);
    rr0 = rr_count;
    repeat (3)
    begin
      repeat (100) @(posedge ref_clk);
      wr(CL, {24'h0, e});
      rd(CN, v, r);
      chk("reload", 32'h0000_0001, {31'h0, v >= 32'h0000_003c});
      e = lfsr_next(e);
    end
    chk("no reset", rr0, rr_count);
    wait_irq(t0);
    chk("irq option", rr0, rr_count);
    wr(CL, 32'h0000_0066);
    repeat (3) @(posedge ref_clk);
    chk("mismatch", rr0 + 1, rr_count);
    $display("test secure clear done");
    reset_dut();
    wr(LD, 32'h0000_0020);
    wr(CT, 32'h0000_0020);
    rr0 = rr_count;
    repeat (4)
    begin
      repeat (60) @(posedge ref_clk);
      wr(CL, $random(seed));
    end
    chk("serviced", rr0, rr_count);
    t0 = cyc;
    while (rr_count == rr0)
      @(posedge ref_clk);
    chk_win("timeout", 33 * SRC, cyc - t0, 6);
    chk("no irq", 32'h0000_0000, {31'h0, irq});
    $display("test watchdog expiry done");
    reset_dut();
    wr(CL, 32'h0000_0000);
    wr(LD, 32'h0000_0040);
    wr(CT, 32'h0000_0030);
    rr0 = rr_count;
    wr(CL, 32'h0000_0000);
    repeat (3) @(posedge ref_clk);
    chk("zero seed", rr0 + 1, rr_count);
    $display("test zero seed done");
    print_verdict();
  end
endmodule
